// ==== hw/dma_configuration_slice.sv ====
// module: dma configuration register, burst gating, pacing and interrupts
`timescale 1ns/1ps
module dma_configuration_slice
    import dma_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input dma_cfg_pkg::reg_req_t bus_req,
    output logic [31:0] rdata,
    input dma_cfg_pkg::core_evt_t core_evt,
    output dma_cfg_pkg::core_ctl_t core_ctl,
    output logic irq
);
    import dma_cfg_pkg::*;

    // ========================================================================
    // register state
    logic [31:0] cfg_ff;
    logic [31:0] nxt_cfg;
    logic [2:0] status_ff;
    logic [2:0] nxt_status;
    logic [2:0] mask_ff;
    logic [2:0] nxt_mask;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [2:0] evt_vec;
    logic [2:0] enables;
    logic pacer_allow;

    // events qualified by their configuration enables
    assign enables = {cfg_ff[POS_XFER_IE], cfg_ff[POS_CHAIN_IE],
        cfg_ff[POS_ERR_IE]};
    always_comb
    begin
        evt_vec = '0;
        evt_vec[ST_ERR] = core_evt.xfer_error & enables[0];
        evt_vec[ST_CHAIN] = core_evt.chain_done & enables[1];
        evt_vec[ST_XFER] = core_evt.xfer_done & enables[2];
    end

    // ========================================================================
    // next register values
    always_comb
    begin
        nxt_cfg = cfg_ff;
        nxt_status = status_ff;
        nxt_mask = mask_ff;
        nxt_rdata = '0;
        if (bus_req.wr && bus_req.addr == OFF_CONFIGURATION)
            nxt_cfg = bus_req.wdata & CFG_WRITE_MASK;
        else if (bus_req.wr && bus_req.addr == OFF_IRQ_MASK)
            nxt_mask = bus_req.wdata[2:0];
        // core-driven active bit: start sets, end or error clears
        if (core_evt.xfer_start)
            nxt_cfg[POS_ACTIVE] = 1'b1;
        if (core_evt.xfer_done || core_evt.xfer_error)
            nxt_cfg[POS_ACTIVE] = 1'b0;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                OFF_CONFIGURATION: nxt_rdata = cfg_ff;
                OFF_IRQ_STATUS: nxt_rdata = {29'h0, status_ff};
                OFF_IRQ_MASK: nxt_rdata = {29'h0, mask_ff};
                default: nxt_rdata = '0;
            endcase
            if (bus_req.addr == OFF_IRQ_STATUS)
                nxt_status = '0; // read clears
        end
        nxt_status = nxt_status | evt_vec; // set wins over read clear
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cfg_ff <= CFG_RESET;
            status_ff <= '0;
            mask_ff <= MASK_RESET[2:0];
            rdata_ff <= '0;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            rdata_ff <= nxt_rdata;
        end
    end

    // ========================================================================
    // request pacing
    request_pacer u_pacer (
        .ref_clk(ref_clk),
        .reset(reset),
        .spacing(cfg_ff[POS_SPACING_LO +: 3]),
        .txn_end(core_evt.txn_end),
        .req_allow(pacer_allow)
    );

    // ========================================================================
    // controls to the engine core
    always_comb
    begin
        core_ctl.active = cfg_ff[POS_ACTIVE];
        core_ctl.mode = cfg_ff[POS_MODE_LO +: 2];
        core_ctl.dir = cfg_ff[POS_DIR];
        core_ctl.swap = cfg_ff[POS_SWAP];
        core_ctl.fifo_reset = cfg_ff[21];
        core_ctl.req_allow = pacer_allow;
        if (core_evt.txn_is_chain)
            core_ctl.burst_allow = core_evt.burst_ok;
        else
            core_ctl.burst_allow = core_evt.burst_ok
                & (cfg_ff[POS_MODE_LO +: 2] != 2'h0)
                & ~cfg_ff[POS_BURST_INHIBIT];
    end

    assign rdata = rdata_ff;
    assign irq = |(status_ff & mask_ff);
endmodule // dma_configuration_slice

// ==== include/dma_cfg_pkg.sv ====
// package: register map, field layout and pacing constants for the dma config slice
package dma_cfg_pkg;
    // ========================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CONFIGURATION = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
    // ========================================================================
    // configuration field positions
    localparam int POS_SWAP = 20;
    localparam int POS_BURST_INHIBIT = 19;
    localparam int POS_SPACING_LO = 11;
    localparam int POS_ERR_IE = 10;
    localparam int POS_CHAIN_IE = 9;
    localparam int POS_XFER_IE = 8;
    localparam int POS_ACTIVE = 6;
    localparam int POS_MODE_LO = 2;
    localparam int POS_DIR = 1;
    // writable bits: 21 (fifo reset), 20, 19, 13:8, 6, 3:2, 1
    localparam logic [31:0] CFG_WRITE_MASK = 32'h0038_3f4e;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    // ========================================================================
    // status bit positions
    localparam int ST_ERR = 0;
    localparam int ST_CHAIN = 1;
    localparam int ST_XFER = 2;
    // ========================================================================
    // spacing: code n (1..7) gives a gap of 2^(n+3) clocks
    localparam int SPACING_BASE_SHIFT = 3;
    localparam int GAP_W = 11;
    // ========================================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic xfer_start;  // core begins a transfer
        logic xfer_done;   // data transfer ended normally
        logic chain_done;  // descriptor chain ended
        logic xfer_error;  // transfer stopped on error
        logic txn_end;     // one system-bus dma transaction ended
        logic txn_is_chain;  // that request is a descriptor fetch
        logic burst_ok;    // alignment and count would allow a burst
    } core_evt_t;
    typedef struct packed {
        logic active;
        logic [1:0] mode;
        logic dir;
        logic swap;
        logic fifo_reset;
        logic req_allow;   // system bus may be requested now
        logic burst_allow; // burst permitted for the pending request
    } core_ctl_t;
endpackage

// ==== hw/request_pacer.sv ====
// module: gap timer spacing system-bus dma transactions
`timescale 1ns/1ps
module request_pacer
    import dma_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] spacing,
    input wire logic txn_end,
    output logic req_allow
);
    logic [GAP_W-1:0] gap_ff;
    logic [GAP_W-1:0] nxt_gap;

    // gap length in clocks for a spacing code
    function automatic logic [GAP_W-1:0] gap_len(input logic [2:0] code);
        if (code == 3'h0)
            return '0;
        // widen the shift amount: code 7 plus the base would wrap in 3 bits
        return GAP_W'(1) << (4'(code) + 4'(SPACING_BASE_SHIFT));
    endfunction

    // load on transaction end, count down to zero
    always_comb
    begin
        nxt_gap = gap_ff;
        if (txn_end)
            nxt_gap = gap_len(spacing);
        else if (gap_ff != '0)
            nxt_gap = gap_ff - GAP_W'(1);
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            gap_ff <= '0;
        else
            gap_ff <= nxt_gap;
    end

    assign req_allow = (gap_ff == '0);
endmodule // request_pacer

// ==== verif/dma_slice_monitor.sv ====
// checker: gating and pacing relations at the slice ports
`timescale 1ns/1ps
module dma_slice_monitor
    import dma_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input dma_cfg_pkg::reg_req_t bus_req,
    input wire logic [31:0] rdata,
    input dma_cfg_pkg::core_evt_t core_evt,
    input dma_cfg_pkg::core_ctl_t core_ctl,
    input wire logic irq
);
    logic [31:0] cfg_ff;
    // shadow of software writes to the configuration word
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            cfg_ff <= 32'h0;
        else if (bus_req.wr && bus_req.addr == OFF_CONFIGURATION)
            cfg_ff <= bus_req.wdata;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    burst_inhibit_a: assert property (
        cfg_ff[19] && !core_evt.txn_is_chain |-> !core_ctl.burst_allow)
        else $error("burst while inhibited");
    chain_fetch_a: assert property (
        core_evt.txn_is_chain |-> core_ctl.burst_allow == core_evt.burst_ok)
        else $error("chain fetch burst wrong");
    burst_data_a: assert property (
        !cfg_ff[19] && !core_evt.txn_is_chain |-> core_ctl.burst_allow ==
        (core_ctl.mode != 2'h0 && core_evt.burst_ok)) else $error("burst");
    gap_none_a: assert property (
        core_evt.txn_end && cfg_ff[13:11] == 3'h0 |=> core_ctl.req_allow)
        else $error("gap with code zero");
    gap_hold_a: assert property (
        core_evt.txn_end && cfg_ff[13:11] != 3'h0 |=>
        (!core_ctl.req_allow)[*8])
        else $error("gap too short");
    gap_sixteen_a: assert property (
        core_evt.txn_end && cfg_ff[13:11] == 3'h1 |->
        ##16 !core_ctl.req_allow ##1 core_ctl.req_allow) else $error("gap 16");
    active_clear_a: assert property (
        core_evt.xfer_done || core_evt.xfer_error |=> !core_ctl.active)
        else $error("active not cleared");
    cfg_reserved_a: assert property (
        bus_req.rd && bus_req.addr == OFF_CONFIGURATION |=> rdata[18:14] == 5'h0)
        else $error("reserved bits set");
    cover property (core_evt.txn_end && cfg_ff[13:11] == 3'h7);
    cover property (cfg_ff[19] && core_evt.txn_is_chain);
    cover property ($rose(irq));
endmodule // dma_slice_monitor
bind dma_configuration_slice dma_slice_monitor mon (.ref_clk(ref_clk),
    .reset(reset), .bus_req(bus_req), .rdata(rdata), .core_evt(core_evt),
    .core_ctl(core_ctl), .irq(irq));

// ==== verif/dma_core_model.sv ====
// partner: controller core issuing paced transactions and events
`timescale 1ns/1ps
module dma_core_model
    import dma_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic req_allow,
    input wire logic go,
    input wire logic fetch,
    input wire logic [3:0] evt,
    output dma_cfg_pkg::core_evt_t ev
);
    logic pend;
    // a transaction waits until pacing lets the bus be requested
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            pend <= 1'b0;
        else
            pend <= go | (pend & ~req_allow);
    end
    // events: start, done, chain, error, then one-cycle transaction end
    assign ev = {evt, pend & req_allow, fetch, 1'b1};
endmodule // dma_core_model

// ==== verif/testbench.sv ====
// testbench: register, pacing, burst and interrupt sequences
`timescale 1ns/1ps
module testbench;
    import dma_cfg_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic go = 1'b0;
    logic fetch = 1'b0;
    logic [3:0] evt = 4'h0;
    reg_req_t req = '0;
    logic [31:0] rdata;
    core_evt_t ev;
    core_ctl_t ctl;
    logic irq;
    int err_total = 0;
    int check_count = 0;
    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;
    dma_configuration_slice dut (.ref_clk(ref_clk), .reset(reset),
        .bus_req(req), .rdata(rdata), .core_evt(ev), .core_ctl(ctl), .irq(irq));
    dma_core_model core (.ref_clk(ref_clk), .reset(reset),
        .req_allow(ctl.req_allow), .go(go), .fetch(fetch), .evt(evt), .ev(ev));
    task finish_test();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge ref_clk);
        req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge ref_clk);
        req.rd <= 1'b0;
        @(negedge ref_clk);
        chk(rdata, e);
        @(posedge ref_clk);
    endtask
    task pulse(input logic [3:0] v, input logic e);
        evt <= v;
        @(posedge ref_clk);
        evt <= 4'h0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(irq, e);
        @(posedge ref_clk);
    endtask
    task gap(input logic [2:0] n);
        int c;
        c = 0;
        wr(OFF_CONFIGURATION, {18'h0, n, 11'h0});
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (1100)
        begin
            @(negedge ref_clk);
            if (ctl.req_allow !== 1'b1)
                c++;
        end
        chk(c, n == 3'h0 ? 0 : 8 << n);
        @(posedge ref_clk);
    endtask
    // watchdog
    initial
    begin
        #1ms;
        err_total++;
        finish_test();
    end
    // main sequence
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(OFF_CONFIGURATION, 32'h0);
        rd(8'h04, 32'h0);
        wr(OFF_CONFIGURATION, 32'hffc7_ff00);
        rd(OFF_CONFIGURATION, 32'h0000_3f00);
        for (int n = 0; n < 8; n++)
            gap(3'(n));
        for (int i = 0; i < 8; i++)
        begin
            wr(OFF_CONFIGURATION, {12'h0, i[0], 16'h0, i[1], 2'h0});
            fetch <= i[2];
            @(negedge ref_clk);
            chk(ctl.burst_allow, i[2] | (i[1] & ~i[0]));
            @(posedge ref_clk);
        end
        fetch <= 1'b0;
        // plain control fields reach the core unchanged
        wr(OFF_CONFIGURATION, 32'h0038_000e);
        @(negedge ref_clk);
        chk({ctl.fifo_reset, ctl.swap, ctl.mode, ctl.dir}, 32'h1f);
        @(posedge ref_clk);
        rd(OFF_CONFIGURATION, 32'h0038_000e);
        wr(OFF_IRQ_MASK, 32'h5);
        wr(OFF_CONFIGURATION, 32'h0000_0740);
        pulse(4'h1, 1'b1);
        rd(OFF_IRQ_STATUS, 32'h1);
        rd(OFF_CONFIGURATION, 32'h0000_0700);
        pulse(4'h2, 1'b0);
        rd(OFF_IRQ_STATUS, 32'h2);
        pulse(4'h8, 1'b0);
        rd(OFF_CONFIGURATION, 32'h0000_0740);
        pulse(4'h4, 1'b1);
        rd(OFF_IRQ_STATUS, 32'h4);
        rd(OFF_CONFIGURATION, 32'h0000_0700);
        wr(OFF_CONFIGURATION, 32'h0);
        pulse(4'h7, 1'b0);
        rd(OFF_IRQ_STATUS, 32'h0);
        finish_test();
    end
endmodule // testbench
